// >>> core/event_flags_consts.svh
// constants of the upper event flag status register
`ifndef EVENT_FLAGS_CONSTS_SVH
`define EVENT_FLAGS_CONSTS_SVH

`define FLAG_WORD_W 32
`define FLAG_RST 32'h0000_0000
// every bit that can hold a flag; 31:28 live elsewhere, 19 reserved
`define FLAG_MASK 32'h0ff7_ffe0
`define PHASE_RST 3'h0

`define POS_CRC_DONE 27
`define POS_CONFIG_CHECKSUM_CHANGED_FLAG 26
`define POS_SAG_A 23
`define POS_SURGE_A 20
`define POS_RESERVED 19
`define POS_ORDER_FAULT 18
`define POS_OVERCURRENT 17
`define POS_STARTUP 16
`define POS_CUR_ZX_A 13
`define POS_COMB_ZX 12
`define POS_VOLT_ZX_A 9
`define POS_ZX_TIMEOUT_A 6
`define POS_FVA_IDLE 5

`endif

// >>> core/event_flags_pkg.sv
// types shared by the event flag modules
package event_flags_pkg;
  typedef logic [31:0] flag_word_t;
  typedef logic [2:0] phase_vec_t;
endpackage

// >>> core/flag_bank_if.sv
// carrier between the register front end and the sticky flag bank
`timescale 1ns/1ps
`default_nettype none
interface flag_bank_if;
  import event_flags_pkg::*;
  flag_word_t set_vec;
  flag_word_t clr_vec;
  flag_word_t state;
  modport bank (input set_vec, input clr_vec, output state);
  modport user (output set_vec, output clr_vec, input state);
endinterface
`default_nettype wire

// >>> core/sticky_flag_bank.sv
// bank of sticky flags, set by hardware, cleared by writing one
`timescale 1ns/1ps
`default_nettype none
`include "event_flags_consts.svh"
module sticky_flag_bank
  import event_flags_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  flag_bank_if.bank port_b
);

  flag_word_t state_r;
  flag_word_t state_nxt;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = ((state_r & ~port_b.clr_vec) | port_b.set_vec) & `FLAG_MASK;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_r <= `FLAG_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign port_b.state = state_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_set_holds_flag: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    ($past(state_r) & ~$past(port_b.clr_vec) & `FLAG_MASK) ==
    (($past(state_r) & ~$past(port_b.clr_vec) & `FLAG_MASK) & state_r)
  ) else $error("flag dropped without a clear");

endmodule
`default_nettype wire

// >>> core/metering_event_status_flags.sv
// upper event flag status register with its phase and checksum side registers
`timescale 1ns/1ps
`default_nettype none
`include "event_flags_consts.svh"

// How it works
// - bit 27 sets when a forced configuration checksum run completes.
// - bit 26 sets on checksum change; new checksum is kept in result register.
// - sag flags bits 25,24,23 for C,B,A on entering or leaving sag.
// - surge flags bits 22,21,20 for C,B,A on entering or leaving surge.
// - bit 18 sets on a phase order fault of voltage crossings.
// - bit 17 sets on any overcurrent; affected phases kept separately.
// - bit 16 sets when start-up finishes; host configures after that.
// - current crossing flags bits 15,14,13 for phases C,B,A.
// - bit 12 sets on a crossing of the combined voltage signal.
// - voltage crossing flags bits 11,10,9 for phases C,B,A.
// - crossing timeout flags bits 8,7,6 for phases C,B,A.
// - bit 5 sets on fundamental apparent idle change; phase kept separately.
// - bit 19 is reserved and always reads zero.
module metering_event_status_flags
  import event_flags_pkg::*;
#(
  parameter int CHECKSUM_W = 32
)(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_wr_en,
  input wire logic [31:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic i_crc_done,
  input wire logic i_crc_change,
  input wire logic [CHECKSUM_W-1:0] i_crc_value,
  input wire logic [2:0] i_sag_evt,
  input wire logic [2:0] i_surge_evt,
  input wire logic i_order_fault,
  input wire logic [2:0] i_overcurrent_evt,
  input wire logic i_startup_done,
  input wire logic [2:0] i_current_zx,
  input wire logic i_combined_zx,
  input wire logic [2:0] i_voltage_zx,
  input wire logic [2:0] i_zx_timeout,
  input wire logic [2:0] i_fva_idle_evt,
  output logic [31:0] o_rd_data,
  output logic o_rd_valid,
  output logic [31:0] o_status,
  output logic [CHECKSUM_W-1:0] o_checksum_result,
  output logic [2:0] o_overcurrent_phase,
  output logic [2:0] o_idle_phase,
  output logic o_config_ready
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (CHECKSUM_W < 1 || CHECKSUM_W > 32) begin : g_bad_width
    $error("CHECKSUM_W must lie between 1 and 32");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // place a three-phase vector a,b,c at a base position a
  function automatic flag_word_t at_phase(input phase_vec_t v,
                                          input int base);
    flag_word_t w;
    w = '0;
    w[base] = v[0];
    w[base + 1] = v[1];
    w[base + 2] = v[2];
    return w;
  endfunction

  function automatic flag_word_t at_bit(input logic v, input int pos);
    flag_word_t w;
    w = '0;
    w[pos] = v;
    return w;
  endfunction

  // ---------------------------------------------------------------
  // sticky flag bank
  // ---------------------------------------------------------------
  flag_bank_if bank_c ();

  sticky_flag_bank u_bank (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .port_b(bank_c.bank)
  );

  flag_word_t set_word;
  flag_word_t clr_word;

  always_comb begin
    set_word = '0;
    set_word |= at_bit(i_crc_done, `POS_CRC_DONE);
    set_word |= at_bit(i_crc_change, `POS_CONFIG_CHECKSUM_CHANGED_FLAG);
    set_word |= at_phase(i_sag_evt, `POS_SAG_A);
    set_word |= at_phase(i_surge_evt, `POS_SURGE_A);
    set_word |= at_bit(i_order_fault, `POS_ORDER_FAULT);
    set_word |= at_bit(|i_overcurrent_evt, `POS_OVERCURRENT);
    set_word |= at_bit(i_startup_done, `POS_STARTUP);
    set_word |= at_phase(i_current_zx, `POS_CUR_ZX_A);
    set_word |= at_bit(i_combined_zx, `POS_COMB_ZX);
    set_word |= at_phase(i_voltage_zx, `POS_VOLT_ZX_A);
    set_word |= at_phase(i_zx_timeout, `POS_ZX_TIMEOUT_A);
    set_word |= at_bit(|i_fva_idle_evt, `POS_FVA_IDLE);
    clr_word = i_wr_en ? i_wr_data : '0;
  end

  assign bank_c.set_vec = set_word;
  assign bank_c.clr_vec = clr_word;

  // ---------------------------------------------------------------
  // side registers and read port
  // ---------------------------------------------------------------
  logic [CHECKSUM_W-1:0] checksum_r;
  logic [CHECKSUM_W-1:0] checksum_nxt;
  phase_vec_t oc_phase_r;
  phase_vec_t oc_phase_nxt;
  phase_vec_t idle_phase_r;
  phase_vec_t idle_phase_nxt;
  flag_word_t rd_data_r;
  flag_word_t rd_data_nxt;
  logic rd_valid_r;
  logic rd_valid_nxt;
  logic cfg_ready_r;
  logic cfg_ready_nxt;
  logic oc_clear;
  logic idle_clear;

  always_comb begin
    oc_clear = clr_word[`POS_OVERCURRENT];
    idle_clear = clr_word[`POS_FVA_IDLE];
    checksum_nxt = i_crc_change ? i_crc_value : checksum_r;
    // phases gather until the flag is cleared; a new one wins
    oc_phase_nxt = (oc_clear ? `PHASE_RST : oc_phase_r) | i_overcurrent_evt;
    // same treatment for idle change phases
    idle_phase_nxt = (idle_clear ? `PHASE_RST : idle_phase_r) |
                     i_fva_idle_evt;
    // once started up, configuration stays allowed until reset
    cfg_ready_nxt = cfg_ready_r | i_startup_done;
    // reserved and unused bits read zero through the mask
    rd_data_nxt = i_rd_en ? (bank_c.state & `FLAG_MASK) : rd_data_r;
    rd_valid_nxt = i_rd_en;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      checksum_r <= '0;
      oc_phase_r <= `PHASE_RST;
      idle_phase_r <= `PHASE_RST;
      cfg_ready_r <= 1'b0;
      rd_data_r <= `FLAG_RST;
      rd_valid_r <= 1'b0;
    end else begin
      checksum_r <= checksum_nxt;
      oc_phase_r <= oc_phase_nxt;
      idle_phase_r <= idle_phase_nxt;
      cfg_ready_r <= cfg_ready_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign o_status = bank_c.state;
  assign o_checksum_result = checksum_r;
  assign o_overcurrent_phase = oc_phase_r;
  assign o_idle_phase = idle_phase_r;
  assign o_config_ready = cfg_ready_r;
  assign o_rd_data = rd_data_r;
  assign o_rd_valid = rd_valid_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_read_req;
    i_rd_en;
  endsequence

  sequence s_read_ans;
    o_rd_valid && o_rd_data == $past(o_status);
  endsequence

  a_crc_done_sets: assert property (
    i_crc_done |=> o_status[27]
  ) else $error("checksum done flag not set");

  a_config_checksum_changed_flag_loads: assert property (
    i_crc_change |=> o_status[26] && o_checksum_result == $past(i_crc_value)
  ) else $error("checksum change not recorded");

  a_sag_phase_c: assert property (
    i_sag_evt == 3'h4 && !i_wr_en |=> o_status[25:23] ==
    ($past(o_status[25:23]) | 3'h4)
  ) else $error("sag flag landed on wrong bit");

  a_surge_phase_a: assert property (
    i_surge_evt[0] |=> o_status[20]
  ) else $error("surge flag a not set");

  a_surge_phase_c: assert property (
    i_surge_evt[2] |=> o_status[22]
  ) else $error("surge flag c not set");

  a_order_fault_sets: assert property (
    i_order_fault |=> o_status[18]
  ) else $error("phase order flag not set");

  a_overcurrent_phase: assert property (
    |i_overcurrent_evt |=> o_status[17] &&
    (o_overcurrent_phase & $past(i_overcurrent_evt)) ==
    $past(i_overcurrent_evt)
  ) else $error("overcurrent phase not recorded");

  a_startup_ready: assert property (
    i_startup_done |=> o_status[16] ##1 o_config_ready
  ) else $error("start-up completion not shown");

  a_current_zx_b: assert property (
    i_current_zx[1] |=> o_status[14]
  ) else $error("current crossing b not set");

  a_combined_zx: assert property (
    i_combined_zx |=> o_status[12]
  ) else $error("combined crossing not set");

  a_voltage_zx_c: assert property (
    i_voltage_zx[2] |=> o_status[11]
  ) else $error("voltage crossing c not set");

  a_timeout_a: assert property (
    i_zx_timeout[0] |=> o_status[6]
  ) else $error("crossing timeout a not set");

  a_idle_change: assert property (
    i_fva_idle_evt[1] |=> o_status[5] && o_idle_phase[1]
  ) else $error("idle change not recorded");

  a_reserved_zero: assert property (
    s_read_req |=> !o_rd_data[19] && o_rd_data[31:28] == 4'h0
  ) else $error("reserved bits read nonzero");

  a_read_answer: assert property (
    s_read_req |=> s_read_ans
  ) else $error("read data does not match flags");

  a_clear_by_one: assert property (
    o_status[13] && i_wr_en && i_wr_data[13] && !i_current_zx[0]
    |=> !o_status[13]
  ) else $error("write of one did not clear flag");

  a_zero_write_keeps: assert property (
    o_status[9] && i_wr_en && !i_wr_data[9] |=> o_status[9] [*1]
  ) else $error("write of zero cleared a flag");

  a_set_beats_clear: assert property (
    i_sag_evt[0] && i_wr_en && i_wr_data[23] |=> o_status[23]
  ) else $error("event lost against a clear");

  a_flag_stays: assert property (
    o_status[27] && !i_wr_en [*1] |=> o_status[27]
  ) else $error("flag dropped by itself");

  a_surge_phase_b: assert property (
    i_surge_evt[1] |=> o_status[21]
  ) else $error("surge flag b not set");

  a_ready_sticky: assert property (
    o_config_ready |=> o_config_ready
  ) else $error("configuration ready dropped");

  a_read_pulse: assert property (
    !i_rd_en |=> !o_rd_valid
  ) else $error("read valid without a request");

  a_oc_phase_clear: assert property (
    i_wr_en && i_wr_data[17] && i_overcurrent_evt == 3'h0
    |=> o_overcurrent_phase == 3'h0
  ) else $error("overcurrent phases not cleared");

  a_idle_phase_clear: assert property (
    i_wr_en && i_wr_data[5] && i_fva_idle_evt == 3'h0
    |=> o_idle_phase == 3'h0
  ) else $error("idle phases not cleared");

endmodule
`default_nettype wire

// >>> testbench/host_port_model.sv
// host side model that clears and reads the flag register
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input wire logic i_clock,
  output logic o_wr_en,
  output logic [31:0] o_wr_data,
  output logic o_rd_en
);
  initial begin
    o_wr_en = 1'b0;
    o_wr_data = 32'h0000_0000;
    o_rd_en = 1'b0;
  end
  // clear by one
  // data lines carry the inverse when idle so stale values never match
  task automatic access(input logic wr, input logic [31:0] d,
                        input logic rd);
    o_wr_en = wr;
    o_wr_data = wr ? d : ~d;
    o_rd_en = rd;
    @(posedge i_clock);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> testbench/metering_event_status_flags_bench.sv
// self-checking bench of the upper event flag status register
`timescale 1ns/1ps
`default_nettype none
`include "event_flags_consts.svh"
module metering_event_status_flags_bench;
  import event_flags_pkg::*;
  logic i_clock, i_sys_rst, wr_en, rd_en, crc_done, config_checksum_changed_flag, order_f;
  logic startup, comb_zx, cfg_rdy, rd_valid;
  logic [31:0] wr_data, crc_val, rd_data, status, chk;
  logic [2:0] sag, surge, oc, czx, vzx, zto, idl, oc_ph, idl_ph;
  flag_word_t exp_st, exp_q[$];
  logic [31:0] exp_chk, seed;
  phase_vec_t exp_oc, exp_idl;
  logic exp_rdy;
  int n_mismatch, n_compared, cycles;
  host_port_model HOST (.i_clock(i_clock), .o_wr_en(wr_en),
    .o_wr_data(wr_data), .o_rd_en(rd_en));
  metering_event_status_flags DUT (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_wr_en(wr_en), .i_wr_data(wr_data),
    .i_rd_en(rd_en), .i_crc_done(crc_done), .i_crc_change(config_checksum_changed_flag),
    .i_crc_value(crc_val), .i_sag_evt(sag), .i_surge_evt(surge),
    .i_order_fault(order_f), .i_overcurrent_evt(oc),
    .i_startup_done(startup), .i_current_zx(czx),
    .i_combined_zx(comb_zx), .i_voltage_zx(vzx), .i_zx_timeout(zto),
    .i_fva_idle_evt(idl), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
    .o_status(status), .o_checksum_result(chk),
    .o_overcurrent_phase(oc_ph), .o_idle_phase(idl_ph),
    .o_config_ready(cfg_rdy));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one cycle of events plus an optional host clear and read
  task automatic step(input flag_word_t ev, input phase_vec_t o,
    input phase_vec_t id, input logic wr, input flag_word_t clr,
    input logic rd);
    flag_word_t s;
    s = ev & `FLAG_MASK & ~32'h0002_0020;
    s[`POS_OVERCURRENT] = |o;
    s[`POS_FVA_IDLE] = |id;
    crc_done = s[27]; config_checksum_changed_flag = s[26]; sag = s[25:23]; surge = s[22:20];
    order_f = s[18]; oc = o; startup = s[16]; czx = s[15:13];
    comb_zx = s[12]; vzx = s[11:9]; zto = s[8:6]; idl = id;
    seed = xs(seed);
    crc_val = seed;
    if (s[26]) exp_chk = seed;
    if (rd) exp_q.push_back(exp_st);
    if (wr && clr[17]) exp_oc = 3'h0;
    if (wr && clr[5]) exp_idl = 3'h0;
    exp_oc = exp_oc | o;
    exp_idl = exp_idl | id;
    exp_rdy = exp_rdy | s[16];
    exp_st = (exp_st & ~(wr ? clr : 32'h0)) | s;
    HOST.access(wr, clr, rd);
    check(status === exp_st, "status word");
    check(oc_ph === exp_oc, "overcurrent phases");
    check(idl_ph === exp_idl, "idle phases");
    check(chk === exp_chk, "checksum result");
    check(cfg_rdy === exp_rdy, "config ready");
  endtask
  task automatic apply_reset();
    i_sys_rst = 1'b1;
    repeat (5) @(posedge i_clock);
    #1;
    i_sys_rst = 1'b0;
    exp_st = 32'h0; exp_oc = 3'h0; exp_idl = 3'h0;
    exp_chk = 32'h0; exp_rdy = 1'b0;
  endtask
  // ----------------------------------------
  // read scoreboard and timeout
  // ----------------------------------------
  always @(posedge i_clock) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "unrequested read");
      else check(rd_data === exp_q.pop_front(), "read data");
    end
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_mismatch = 0; n_compared = 0; cycles = 0; seed = 32'h0000_0026;
    exp_st = 32'h0; exp_oc = 3'h0; exp_idl = 3'h0;
    exp_chk = 32'h0; exp_rdy = 1'b0;
    i_sys_rst = 1'b1;
    step(32'h0, 3'h0, 3'h0, 1'b0, 32'h0, 1'b0);
    apply_reset();
    step(32'h0, 3'h0, 3'h0, 1'b0, 32'h0, 1'b1);
    for (int b = 5; b < 28; b++) begin
      if (b == 19) continue;
      step(32'h1 << b, (b == 17) ? 3'h2 : 3'h0, (b == 5) ? 3'h4 : 3'h0,
           1'b0, 32'h0, 1'b0);
      step(32'h0, 3'h0, 3'h0, 1'b1, ~(32'h1 << b), 1'b1);
      step(32'h0, 3'h0, 3'h0, 1'b1, 32'h1 << b, 1'b1);
      step(32'h0, 3'h0, 3'h0, 1'b0, 32'h0, 1'b1);
    end
    step(32'hffff_ffff, 3'h7, 3'h7, 1'b0, 32'h0, 1'b1);
    step(32'h0, 3'h0, 3'h0, 1'b1, 32'hffff_ffff, 1'b1);
    for (int i = 0; i < 300; i++) begin
      seed = xs(seed);
      step(seed & xs(seed), seed[2:0], seed[5:3], seed[7], xs(seed ^ 32'h5a),
           seed[9]);
    end
    apply_reset();
    step(32'h0, 3'h0, 3'h0, 1'b0, 32'h0, 1'b1);
    repeat (3) step(32'h0, 3'h0, 3'h0, 1'b0, 32'h0, 1'b0);
    check(exp_q.size() == 0, "missing read answers");
    print_verdict();
  end
endmodule
`default_nettype wire
